// file: src/address_mark_detector.v
// Behaviour
// - With search enable low, no shifting happens and all detect and data outputs stay inactive.
// - With search enable high, data and clock bits are shifted into the shift registers.
// - Each data bit is shifted into the data register on the falling read clock edge.
// - Each clock bit is shifted into the clock register on the falling edge of the complementary read clock.
// - The delayed data output takes the bit shifted out of the last data register stage, eight bits behind the input.
// - After each shift the sixteen register bits are compared with data A1 and clock 0A.
// - On a match the low-active detect output goes low and the high-active one goes high.
// - The detect outputs stay latched until search enable goes low.
// - After detection the data strobe toggles so the delayed data can be clocked out.
// - The data strobe stays inactive while search enable is low.
// - A rising edge on the latch trigger drives the latch output low.
// - A low latch clear returns the latch output high after the two-flop synchroniser delay.
// - Active-low test pulses mark a data A1 and a clock 0A in the registers.
`timescale 1ns/1ns
`include "mark_detector_map.vh"
module address_mark_detector #(
  parameter WIDTH = `AMD_SHIFT_WIDTH
) (
  // system
  input  wire CLK_I,
  input  wire SYS_RST_I,
  // read channel pins
  input  wire READ_CLK_I,
  input  wire READ_CLK_N_I,
  input  wire NRZ_DATA_I,
  input  wire CLOCK_BITS_I,
  input  wire SEARCH_ENABLE_I,
  // detect and data out
  output reg  MARK_FOUND_O,
  output reg  MARK_FOUND_N_O,
  output reg  DELAYED_DATA_O,
  output reg  DATA_STROBE_O,
  output reg  FIRST_BYTE_HIT_N_O,
  output reg  SECOND_BYTE_HIT_N_O,
  // uncommitted latch
  input  wire LATCH_TRIGGER_I,
  input  wire LATCH_CLEAR_N_I,
  output reg  LATCH_O
);

  // two-flop synchronisers for all read channel and latch pins; system reset is used unsynchronised
  reg [6:0] s1_q;
  reg [6:0] s2_q;
  reg [6:0] s3_q;
  always @(posedge CLK_I) begin
    s1_q <= {LATCH_CLEAR_N_I, LATCH_TRIGGER_I, SEARCH_ENABLE_I, CLOCK_BITS_I,
             NRZ_DATA_I, READ_CLK_N_I, READ_CLK_I};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  wire rclk_fall  = s3_q[0] & ~s2_q[0];
  wire rclkn_fall = s3_q[1] & ~s2_q[1];
  wire din        = s2_q[2];
  wire cin        = s2_q[3];
  wire enable     = s2_q[4];
  wire trig_rise  = s2_q[5] & ~s3_q[5];
  wire clear_n    = s2_q[6];

  reg [WIDTH-1:0] data_sr_q;
  reg [WIDTH-1:0] clk_sr_q;
  reg             found_q;
  reg             data_shifted_q;
  reg             clk_shifted_q;
  wire data_hit = (data_sr_q == `AMD_DATA_PATTERN);
  wire clk_hit  = (clk_sr_q == `AMD_CLOCK_PATTERN);

  always @(posedge CLK_I) begin
    if (SYS_RST_I || !enable) begin
      data_sr_q           <= {WIDTH{1'b0}};
      clk_sr_q            <= {WIDTH{1'b0}};
      found_q             <= 1'b0;
      data_shifted_q      <= 1'b0;
      clk_shifted_q       <= 1'b0;
      MARK_FOUND_O        <= 1'b0;
      MARK_FOUND_N_O      <= 1'b1;
      DELAYED_DATA_O      <= 1'b0;
      DATA_STROBE_O       <= 1'b0;
      FIRST_BYTE_HIT_N_O  <= 1'b1;
      SECOND_BYTE_HIT_N_O <= 1'b1;
    end else begin
      data_shifted_q <= rclk_fall;
      clk_shifted_q  <= rclkn_fall;
      if (rclk_fall) begin
        data_sr_q <= {data_sr_q[WIDTH-2:0], din};
      end
      if (rclkn_fall) begin
        clk_sr_q <= {clk_sr_q[WIDTH-2:0], cin};
      end
      // compare one cycle after a shift, once registers settled
      if ((data_shifted_q || clk_shifted_q) && data_hit && clk_hit) begin
        found_q        <= 1'b1;
        MARK_FOUND_O   <= 1'b1;
        MARK_FOUND_N_O <= 1'b0;
      end
      FIRST_BYTE_HIT_N_O  <= ~(data_shifted_q && data_hit);
      SECOND_BYTE_HIT_N_O <= ~(clk_shifted_q && clk_hit);
      // bit leaving the last stage, so a bit reappears eight shifts later
      if (rclk_fall) begin
        DELAYED_DATA_O <= data_sr_q[WIDTH-1];
      end
      // strobe low on shift, high a cycle after data out updates
      if (rclk_fall) begin
        DATA_STROBE_O <= 1'b0;
      end else if (found_q && data_shifted_q) begin
        DATA_STROBE_O <= 1'b1;
      end
    end
  end

  // latch runs on sampled edges; clear dominates, so it acts within sync delay
  always @(posedge CLK_I) begin
    if (SYS_RST_I || !clear_n) begin
      LATCH_O <= 1'b1;
    end else if (trig_rise) begin
      LATCH_O <= 1'b0;
    end
  end

endmodule

// file: include/mark_detector_map.vh
`ifndef MARK_DETECTOR_MAP_VH
`define MARK_DETECTOR_MAP_VH
`define AMD_DATA_PATTERN   8'hA1
`define AMD_CLOCK_PATTERN  8'h0A
`define AMD_SHIFT_WIDTH    8
`define AMD_DELAY_BITS     8
`endif

// file: test/amd_chk.sv
`timescale 1ns/1ns
module amd_chk (input wire CLK_I, SYS_RST_I, SEARCH_ENABLE_I, MARK_FOUND_O, DATA_STROBE_O,
  DELAYED_DATA_O, MARK_FOUND_N_O, FIRST_BYTE_HIT_N_O, LATCH_CLEAR_N_I, LATCH_O);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_off; !SEARCH_ENABLE_I [*4]; endsequence
  property p_off; s_off |-> !MARK_FOUND_O && !DATA_STROBE_O; endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_stb; $rose(DATA_STROBE_O) |-> MARK_FOUND_O && $stable(DELAYED_DATA_O); endproperty
  a_stb: assert property (p_stb) else $error("strobe early");
  property p_pair; MARK_FOUND_O == !MARK_FOUND_N_O; endproperty
  a_pair: assert property (p_pair) else $error("detect pair split");
  property p_hold; MARK_FOUND_O && SEARCH_ENABLE_I |=> MARK_FOUND_O; endproperty
  a_hold: assert property (p_hold) else $error("detect dropped");
  property p_stbf; DATA_STROBE_O |-> MARK_FOUND_O; endproperty
  a_stbf: assert property (p_stbf) else $error("strobe without mark");
  property p_hit; !FIRST_BYTE_HIT_N_O |=> FIRST_BYTE_HIT_N_O; endproperty
  a_hit: assert property (p_hit) else $error("hit pulse too long");
  sequence s_clr; !LATCH_CLEAR_N_I [*4]; endsequence
  property p_clr; s_clr |-> LATCH_O; endproperty
  a_clr: assert property (p_clr) else $error("latch not cleared");
endmodule
bind address_mark_detector amd_chk u_chk (.*);

// file: test/amd_sep.sv
`timescale 1ns/1ns
module amd_sep (output reg r_o = 1, rn_o = 0, d_o = 0, c_o = 0);
  task send(input [7:0] d, c);
    for (int i = 7; i >= 0; i--) begin
      {d_o, c_o} = {d[i], c[i]};
      #80 {r_o, rn_o} = 2'h1;
      #160 {r_o, rn_o} = 2'h2;
      #80 {d_o, c_o} = ~{d[i], c[i]};
    end
  endtask
endmodule

// file: test/test_address_mark_detector.sv
`timescale 1ns/1ns
module test_address_mark_detector;
  reg CLK_I = 0, SYS_RST_I = 1, SEARCH_ENABLE_I = 0, LATCH_TRIGGER_I = 0, LATCH_CLEAR_N_I = 1;
  wire READ_CLK_I, READ_CLK_N_I, NRZ_DATA_I, CLOCK_BITS_I, DATA_STROBE_O, DELAYED_DATA_O;
  wire MARK_FOUND_O, LATCH_O;
  reg [7:0] cap = 8'h0;
  integer err_total = 0, check_count = 0, cyc = 0;
  amd_sep sep (.r_o(READ_CLK_I), .rn_o(READ_CLK_N_I), .d_o(NRZ_DATA_I), .c_o(CLOCK_BITS_I));
  address_mark_detector DUT (.*, .MARK_FOUND_N_O(),
    .FIRST_BYTE_HIT_N_O(), .SECOND_BYTE_HIT_N_O());
  initial forever #20 CLK_I = ~CLK_I;
  always @(posedge DATA_STROBE_O) cap <= {cap[6:0], DELAYED_DATA_O};
  always @(posedge CLK_I) if (++cyc == 2000) begin err_total++; complete_run; end
  task chk(input [7:0] g, e);
    check_count++;
    if (g !== e) $display("[FAIL] %0t %h %h", $time, g, e);
    err_total += (g !== e);
  endtask
  task complete_run;
    $display("%0d checks %0d errors", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task t_mark;
    @(negedge CLK_I) SEARCH_ENABLE_I = 1;
    sep.send(8'hA1, 8'h0B); #200 chk(MARK_FOUND_O, 8'h0);
    sep.send(8'hA1, 8'h0A); #200 chk(MARK_FOUND_O, 8'h1);
    cap = 8'h0; sep.send(8'h3C, 8'h0); #200 chk(cap, 8'hA1);
    @(negedge CLK_I) SEARCH_ENABLE_I = 0;
    sep.send(8'hA1, 8'h0A); chk({MARK_FOUND_O, DATA_STROBE_O}, 8'h0);
    $display("mark done");
  endtask
  task t_latch;
    @(negedge CLK_I) LATCH_TRIGGER_I = 1; #200 chk(LATCH_O, 8'h0);
    @(negedge CLK_I) LATCH_CLEAR_N_I = 0; #200 chk(LATCH_O, 8'h1);
    $display("latch done");
  endtask
  initial begin
    repeat (16) @(negedge CLK_I);
    SYS_RST_I = 0;
    t_mark;
    t_latch;
    complete_run;
  end
endmodule
